// ==== core/cdr_top.v ====
`timescale 1ns/1ps
`include "cdr_defines.vh"

module cdr_top (
	input wire i_ref_clk,
	input wire i_sys_rst,
	input wire i_clk_en,
	// fields of the core configuration register
	input wire i_way_select_field,
	input wire i_information_select_field,
	// debug read requests from the execute stage
	input wire i_icread_req,
	input wire i_dcread_req,
	input wire [31:0] i_effective_address,
	input wire [4:0] i_dest_gpr,
	output wire o_busy,
	// special register read port
	input wire i_spr_rd,
	input wire i_spr_wr,
	input wire [9:0] i_spr_num,
	input wire i_priv,
	output reg o_spr_ack,
	output reg o_spr_fault,
	output reg [31:0] o_spr_data,
	// general purpose register write port
	output reg o_gpr_we,
	output reg [4:0] o_gpr_addr,
	output reg [31:0] o_gpr_data,
	// instruction cache arrays, read only
	output reg o_ic_arr_rd,
	output reg [4:0] o_ic_arr_index,
	output reg [2:0] o_ic_arr_word,
	input wire [21:0] i_ic_tag_a,
	input wire [21:0] i_ic_tag_b,
	input wire [31:0] i_ic_word_a,
	input wire [31:0] i_ic_word_b,
	input wire i_ic_valid_a,
	input wire i_ic_valid_b,
	input wire i_ic_lru,
	// data cache arrays, read only
	output reg o_dc_arr_rd,
	output reg [7:0] o_dc_arr_index,
	output reg [2:0] o_dc_arr_word,
	input wire [18:0] i_dc_tag_a,
	input wire [18:0] i_dc_tag_b,
	input wire [31:0] i_dc_word_a,
	input wire [31:0] i_dc_word_b,
	input wire i_dc_valid_a,
	input wire i_dc_valid_b,
	input wire i_dc_dirty_a,
	input wire i_dc_dirty_b,
	input wire i_dc_lru
);

	localparam [1:0] S_IDLE = 2'b00;
	localparam [1:0] S_ISSUE = 2'b01;
	localparam [1:0] S_CAPT = 2'b10;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg is_dc_q;
	reg way_q;
	reg cis_q;
	reg [4:0] dest_q;
	reg [31:0] icache_debug_result_q;
	wire [31:0] ic_fmt;
	wire [31:0] dc_fmt;
	wire take;

	assign o_busy = (state_q != S_IDLE);
	// a request arriving while busy is dropped; the core serialises them
	assign take = i_clk_en && !o_busy && (i_icread_req || i_dcread_req);

	always @*
	begin
		state_d = state_q;
		case (state_q)
			S_IDLE:
				if (take)
					state_d = S_ISSUE;
			S_ISSUE:
				state_d = S_CAPT;
			S_CAPT:
				state_d = S_IDLE;
			default:
				state_d = S_IDLE;
		endcase
	end

	// request capture; configuration is frozen with the request
	always @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state_q <= S_IDLE;
			is_dc_q <= 1'b0;
			way_q <= 1'b0;
			cis_q <= 1'b0;
			dest_q <= 5'h00;
		end
		else if (i_clk_en)
		begin
			state_q <= state_d;
			if (take)
			begin
				// instruction read wins a simultaneous pair
				is_dc_q <= !i_icread_req;
				way_q <= i_way_select_field;
				cis_q <= i_information_select_field;
				dest_q <= i_dest_gpr;
			end
		end
	end

	// array read strobes: read only, so no state in the caches moves
	always @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_ic_arr_rd <= 1'b0;
			o_ic_arr_index <= 5'h00;
			o_ic_arr_word <= 3'h0;
			o_dc_arr_rd <= 1'b0;
			o_dc_arr_index <= 8'h00;
			o_dc_arr_word <= 3'h0;
		end
		else if (i_clk_en)
		begin
			o_ic_arr_rd <= take && i_icread_req;
			o_dc_arr_rd <= take && !i_icread_req;
			if (take)
			begin
				o_ic_arr_index <= i_effective_address[`CDR_IC_CLASS_HI:
					`CDR_IC_CLASS_LO];
				o_dc_arr_index <= i_effective_address[`CDR_DC_CLASS_HI:
					`CDR_DC_CLASS_LO];
				o_ic_arr_word <= i_effective_address[`CDR_WORD_HI:
					`CDR_WORD_LO];
				o_dc_arr_word <= i_effective_address[`CDR_WORD_HI:
					`CDR_WORD_LO];
			end
		end
	end

	cdr_way_mux #(
		.LINE_FIELD_A_W(`CDR_IC_LINE_FIELD_A_W)
	) u_ic_mux (
		.i_way(way_q),
		.i_cis(cis_q),
		.i_has_dirty(1'b0),
		.i_tag_a(i_ic_tag_a),
		.i_tag_b(i_ic_tag_b),
		.i_word_a(i_ic_word_a),
		.i_word_b(i_ic_word_b),
		.i_valid_a(i_ic_valid_a),
		.i_valid_b(i_ic_valid_b),
		.i_dirty_a(1'b0),
		.i_dirty_b(1'b0),
		.i_lru(i_ic_lru),
		.o_result(ic_fmt)
	);

	cdr_way_mux #(
		.LINE_FIELD_A_W(`CDR_DC_LINE_FIELD_A_W)
	) u_dc_mux (
		.i_way(way_q),
		.i_cis(cis_q),
		.i_has_dirty(1'b1),
		.i_tag_a(i_dc_tag_a),
		.i_tag_b(i_dc_tag_b),
		.i_word_a(i_dc_word_a),
		.i_word_b(i_dc_word_b),
		.i_valid_a(i_dc_valid_a),
		.i_valid_b(i_dc_valid_b),
		.i_dirty_a(i_dc_dirty_a),
		.i_dirty_b(i_dc_dirty_b),
		.i_lru(i_dc_lru),
		.o_result(dc_fmt)
	);

	// arrays answer one cycle after the strobe, sampled in the capture state
	always @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			icache_debug_result_q <= `CDR_IC_RESULT_RST;
			o_gpr_we <= 1'b0;
			o_gpr_addr <= 5'h00;
			o_gpr_data <= 32'h00000000;
		end
		else if (i_clk_en)
		begin
			o_gpr_we <= (state_q == S_CAPT) && is_dc_q;
			if (state_q == S_CAPT)
			begin
				if (is_dc_q)
				begin
					o_gpr_addr <= dest_q;
					o_gpr_data <= dc_fmt;
				end
				else
					icache_debug_result_q <= ic_fmt;
			end
		end
	end

	// special register port: one cycle answer, writes are refused
	always @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_spr_ack <= 1'b0;
			o_spr_fault <= 1'b0;
			o_spr_data <= 32'h00000000;
		end
		else if (i_clk_en)
		begin
			o_spr_ack <= 1'b0;
			o_spr_fault <= 1'b0;
			if (i_spr_num == `CDR_IC_RESULT_SPR)
			begin
				if (i_spr_wr || (i_spr_rd && !i_priv))
					o_spr_fault <= 1'b1;
				else if (i_spr_rd)
				begin
					o_spr_ack <= 1'b1;
					// the value stored by the last completed instruction read
					o_spr_data <= icache_debug_result_q;
				end
			end
		end
	end

endmodule

// ==== core/cdr_defines.vh ====
// Overview of operation
// - instruction read takes the congruence class from address bits 22 to 26.
// - way select field 0 picks way A, 1 picks way B, for both reads.
// - instruction read loads line information into a 32-bit result register.
// - instruction result bits 0 to 21: word if select is 0, tag if 1.
// - the returned word is picked within the line by address bits 27 to 29.
// - result bit 27 copies the selected line's valid bit.
// - result bit 31 copies the class LRU bit, 1 meaning way B.
// - instruction result is privileged, read-only, special register 979.
// - after a context sync, a read returns the latest instruction result.
// - data read takes the congruence class from address bits 19 to 26.
// - data read writes its result straight into the named register.
// - data result bits 0 to 18: word or tag; word chosen by bits 27 to 29.
// - data result bit 26 copies the line's dirty bit.
`ifndef CDR_DEFINES_VH
`define CDR_DEFINES_VH

// special register number of the instruction debug result
`define CDR_IC_RESULT_SPR 10'h3D3
`define CDR_IC_RESULT_RST 32'h00000000

// effective address fields, msb-0 numbering mapped to little endian
`define CDR_IC_CLASS_HI 9
`define CDR_IC_CLASS_LO 5
`define CDR_DC_CLASS_HI 12
`define CDR_DC_CLASS_LO 5
`define CDR_WORD_HI 4
`define CDR_WORD_LO 2

// result word layout, little endian positions
`define CDR_LINE_FIELD_A_MSB 31
`define CDR_IC_LINE_FIELD_A_W 22
`define CDR_DC_LINE_FIELD_A_W 19
`define CDR_DIRTY_BIT 5
`define CDR_VALID_BIT 4
`define CDR_LRU_BIT 0

`define CDR_WAY_A 1'b0
`define CDR_CIS_WORD 1'b0

`endif

// ==== core/cdr_way_mux.v ====
`timescale 1ns/1ps
`include "cdr_defines.vh"

module cdr_way_mux #(
	parameter LINE_FIELD_A_W = 22
) (
	input wire i_way,
	input wire i_cis,
	input wire i_has_dirty,
	input wire [LINE_FIELD_A_W-1:0] i_tag_a,
	input wire [LINE_FIELD_A_W-1:0] i_tag_b,
	input wire [31:0] i_word_a,
	input wire [31:0] i_word_b,
	input wire i_valid_a,
	input wire i_valid_b,
	input wire i_dirty_a,
	input wire i_dirty_b,
	input wire i_lru,
	output reg [31:0] o_result
);

	reg way_b;

	always @*
	begin
		way_b = (i_way != `CDR_WAY_A);
		o_result = 32'h00000000;
		if (i_cis == `CDR_CIS_WORD)
			// a word is wider than the field: its msb-0 leading bits fit
			o_result[`CDR_LINE_FIELD_A_MSB -: LINE_FIELD_A_W] = way_b ?
				i_word_b[31 -: LINE_FIELD_A_W] : i_word_a[31 -: LINE_FIELD_A_W];
		else
			o_result[`CDR_LINE_FIELD_A_MSB -: LINE_FIELD_A_W] = way_b ? i_tag_b : i_tag_a;
		o_result[`CDR_VALID_BIT] = way_b ? i_valid_b : i_valid_a;
		if (i_has_dirty)
			o_result[`CDR_DIRTY_BIT] = way_b ? i_dirty_b : i_dirty_a;
		o_result[`CDR_LRU_BIT] = i_lru;
	end

endmodule

// ==== tb/cdr_checker.sv ====
`timescale 1ns/1ps
module cdr_checker (
	input wire i_ref_clk,
	input wire i_sys_rst,
	input wire i_clk_en,
	input wire i_icread_req,
	input wire i_dcread_req,
	input wire [31:0] i_effective_address,
	input wire i_spr_rd,
	input wire i_spr_wr,
	input wire [9:0] i_spr_num,
	input wire i_priv,
	input wire o_busy,
	input wire o_spr_ack,
	input wire o_spr_fault,
	input wire o_gpr_we,
	input wire o_ic_arr_rd,
	input wire [4:0] o_ic_arr_index,
	input wire [2:0] o_ic_arr_word,
	input wire o_dc_arr_rd,
	input wire [7:0] o_dc_arr_index,
	input wire [2:0] o_dc_arr_word
);
default clocking cb @(posedge i_ref_clk);
endclocking
default disable iff (i_sys_rst);
ic_index_a: assert property (i_clk_en && i_icread_req && !o_busy |=>
	o_ic_arr_rd && o_ic_arr_index == $past(i_effective_address[9:5])
	&& o_ic_arr_word == $past(i_effective_address[4:2])) else $error("ic idx");
dc_index_a: assert property (i_clk_en && i_dcread_req
	&& !i_icread_req && !o_busy |=> o_dc_arr_rd
	&& o_dc_arr_index == $past(i_effective_address[12:5])
	&& o_dc_arr_word == $past(i_effective_address[4:2])) else $error("dc idx");
busy_span_a: assert property (o_ic_arr_rd |->
	o_busy ##1 o_busy ##1 !o_busy) else $error("busy span");
dc_busy_a: assert property (o_dc_arr_rd |-> o_busy)
	else $error("dc busy");
gpr_pulse_a: assert property (o_dc_arr_rd |-> ##2 o_gpr_we
	##1 !o_gpr_we) else $error("gpr pulse");
spr_ack_a: assert property (i_clk_en && i_spr_rd && i_priv
	&& !i_spr_wr && i_spr_num == 10'h3D3 |=> o_spr_ack && !o_spr_fault)
	else $error("ack");
spr_fault_a: assert property (i_clk_en && i_spr_wr
	&& i_spr_num == 10'h3D3 |=> o_spr_fault && !o_spr_ack) else $error("fault");
spr_silent_a: assert property (i_clk_en && i_spr_num != 10'h3D3 |=>
	!o_spr_ack && !o_spr_fault) else $error("silent");
endmodule
bind cdr_top cdr_checker cdr_checker_inst (.*);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
reg i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1;
reg i_way_select_field = 1'b0, i_information_select_field = 1'b0;
reg i_icread_req = 1'b0, i_dcread_req = 1'b0, i_priv = 1'b0;
reg i_spr_rd = 1'b0, i_spr_wr = 1'b0;
reg [9:0] i_spr_num = 10'h000;
reg [31:0] i_effective_address = 32'h0;
reg [4:0] i_dest_gpr = 5'h00;
reg [21:0] i_ic_tag_a = 22'h15A5C3, i_ic_tag_b = 22'h2A5A3C;
reg [31:0] i_ic_word_a = 32'hC3A50F96, i_ic_word_b = 32'h3C5AF069;
reg [18:0] i_dc_tag_a = 19'h5A5C3, i_dc_tag_b = 19'h25A3C;
reg [31:0] i_dc_word_a = 32'h96F0A5C3, i_dc_word_b = 32'h690F5A3C;
reg i_ic_valid_a = 1'b0, i_ic_valid_b = 1'b0, i_ic_lru = 1'b0;
reg i_dc_valid_a = 1'b0, i_dc_valid_b = 1'b0, i_dc_lru = 1'b0;
reg i_dc_dirty_a = 1'b0, i_dc_dirty_b = 1'b0;
wire o_busy, o_spr_ack, o_spr_fault, o_gpr_we, o_ic_arr_rd, o_dc_arr_rd;
wire [31:0] o_spr_data, o_gpr_data;
wire [4:0] o_gpr_addr, o_ic_arr_index;
wire [7:0] o_dc_arr_index;
wire [2:0] o_ic_arr_word, o_dc_arr_word;
reg [31:0] e;
integer failures = 0, tests_run = 0, i;
cdr_top cdr_top_inst (.*);
always #12.5 i_ref_clk = ~i_ref_clk;
task chk(input [31:0] s, input [31:0] x);
begin
	tests_run = tests_run + 1;
	if (s !== x)
	begin
		failures = failures + 1;
		$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
	end
end
endtask
task end_sim;
begin
	$display("failures=%0d tests_run=%0d", failures, tests_run);
	if (failures == 0 && tests_run > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
end
endtask
task spr(input r, input w, input p, input [9:0] num);
begin
	@(posedge i_ref_clk);
	i_spr_rd <= r;
	i_spr_wr <= w;
	i_priv <= p;
	i_spr_num <= num;
	@(posedge i_ref_clk);
	i_spr_rd <= 1'b0;
	i_spr_wr <= 1'b0;
	#1;
end
endtask
// k[0] picks the way, k[1] picks tag over word; line state varies with k
task go(input ic, input [31:0] ea, input [1:0] k);
integer n;
begin
	@(posedge i_ref_clk);
	i_icread_req <= ic;
	i_dcread_req <= ~ic;
	i_effective_address <= ea;
	i_dest_gpr <= ea[4:0];
	i_way_select_field <= k[0];
	i_information_select_field <= k[1];
	{i_ic_valid_a, i_ic_valid_b, i_ic_lru} <= {k[1], ~k[1], k[0]};
	{i_dc_valid_a, i_dc_valid_b, i_dc_lru} <= {~k[1], k[1], k[1]};
	{i_dc_dirty_a, i_dc_dirty_b} <= {k[0], ~k[1]};
	@(posedge i_ref_clk);
	i_icread_req <= 1'b0;
	i_dcread_req <= 1'b0;
	n = 0;
	#1;
	while (o_busy !== 1'b0 && n < 8)
	begin
		@(posedge i_ref_clk);
		#1;
		n = n + 1;
	end
	chk(n, 2);
	if (n == 8)
		end_sim;
	if (ic)
	begin
		chk(o_ic_arr_index, ea[9:5]);
		chk(o_ic_arr_word, ea[4:2]);
		e = k[0] ? i_ic_word_b : i_ic_word_a;
		e = {k[1] ? (k[0] ? i_ic_tag_b : i_ic_tag_a) : e[31:10], 5'h00,
			k[0] ? i_ic_valid_b : i_ic_valid_a, 3'h0, i_ic_lru};
		spr(1'b1, 1'b0, 1'b1, 10'h3D3);
		chk(o_spr_data, e);
	end
	else
	begin
		chk(o_gpr_we, 1'b1);
		chk(o_gpr_addr, ea[4:0]);
		chk(o_dc_arr_index, ea[12:5]);
		chk(o_dc_arr_word, ea[4:2]);
		e = k[0] ? i_dc_word_b : i_dc_word_a;
		e = {k[1] ? (k[0] ? i_dc_tag_b : i_dc_tag_a) : e[31:13], 7'h00,
			k[0] ? i_dc_dirty_b : i_dc_dirty_a,
			k[0] ? i_dc_valid_b : i_dc_valid_a, 3'h0, i_dc_lru};
		chk(o_gpr_data, e);
	end
end
endtask
// clock enable low: pending requests must leave no trace
task freeze;
begin
	@(posedge i_ref_clk);
	i_clk_en <= 1'b0;
	i_dcread_req <= 1'b1;
	i_spr_rd <= 1'b1;
	i_spr_num <= 10'h3D3;
	i_priv <= 1'b1;
	repeat (3) @(posedge i_ref_clk);
	i_dcread_req <= 1'b0;
	i_spr_rd <= 1'b0;
	i_clk_en <= 1'b1;
	#1;
	chk({o_busy, o_dc_arr_rd, o_gpr_we, o_spr_ack}, 4'h0);
end
endtask
initial
begin
	repeat (10) @(posedge i_ref_clk);
	i_sys_rst <= 1'b0;
	#1;
	chk({o_busy, o_gpr_we, o_ic_arr_rd, o_dc_arr_rd}, 4'h0);
	spr(1'b1, 1'b0, 1'b1, 10'h3D3);
	chk(o_spr_data, 32'h0);
	for (i = 0; i < 4; i = i + 1)
	begin
		go(1'b1, 32'hA5C3F0E4 + i * 32'h0124, i[1:0]);
		go(1'b0, 32'h5A3C0F1B + i * 32'h1328, i[1:0]);
	end
	freeze;
	go(1'b1, 32'hFFFFFFFC, 2'h3);
	spr(1'b1, 1'b0, 1'b0, 10'h3D3);
	chk({o_spr_ack, o_spr_fault}, 2'b01);
	chk(o_spr_data, e);
	spr(1'b0, 1'b1, 1'b1, 10'h3D3);
	chk({o_spr_ack, o_spr_fault}, 2'b01);
	spr(1'b1, 1'b0, 1'b1, 10'h3B1);
	chk({o_spr_ack, o_spr_fault}, 2'b00);
	end_sim;
end
endmodule
